// >>> design/cmf_pkg.sv
/*
 * package for the CAN mode and filter control block: register offsets,
 * field positions, reset values, mode codes and the carrier struct.
 * assumes an AXI4-Lite master with 32-bit data and a 20 MHz clock.
 */
package cmf_pkg;

  // register byte offsets
  localparam logic [3:0] CTRL_OFF   = 4'h0;
  localparam logic [3:0] FEN_OFF    = 4'h4;
  localparam logic [3:0] BUFPNT_OFF = 4'h8;
  localparam logic [3:0] STAT_OFF   = 4'hc;

  // control register field positions
  localparam int IDLE_STOP_BIT = 13;
  localparam int ABORT_BIT     = 12;
  localparam int CLK_SEL_BIT   = 11;
  localparam int REQ_LSB       = 8;
  localparam int STAT_LSB      = 5;
  localparam int CAP_BIT       = 3;
  localparam int WIN_BIT       = 0;

  // reset values
  localparam logic [15:0] FEN_RST    = 16'hffff;
  localparam logic [15:0] BUFPNT_RST = 16'h0000;
  localparam logic [2:0]  REQ_RST    = 3'h4;
  localparam logic [2:0]  STAT_RST   = 3'h4;

  // mode codes shared by request and status
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_DIS    = 3'h1;
  localparam logic [2:0] MODE_LOOP   = 3'h2;
  localparam logic [2:0] MODE_LISTEN = 3'h3;
  localparam logic [2:0] MODE_CONFIG = 3'h4;
  localparam logic [2:0] MODE_RSV5   = 3'h5;
  localparam logic [2:0] MODE_RSV6   = 3'h6;
  localparam logic [2:0] MODE_LALL   = 3'h7;

  // bus idle: recessive bits in a row
  localparam int IDLE_BITS = 11;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // steering outputs toward the protocol engine
  typedef struct packed {
    logic [2:0]  mode;
    logic        abort_req;
    logic        clk_double;
    logic        stopped;
    logic        capture_en;
    logic        window_filters;
    logic [15:0] filter_en;
    logic [15:0] buf_ptr;
  } cmf_ctrl_s;

endpackage

// >>> design/cmf_top.sv
/*
 * CAN mode and filter control registers with an AXI4-Lite slave.
 * assumes the protocol engine supplies a bit strobe, the sampled bus
 * level on the same clock, the per-buffer abort status and rx events.
 */
`timescale 1ns/100ps
`default_nettype none

module cmf_top #(
  parameter int TX_BUFS = 8
) (
  // clock, reset, enable
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // axi4-lite write address, data and response
  input  wire logic [3:0]         s_awaddr,
  input  wire logic               s_awvalid,
  output var  logic               s_awready,
  input  wire logic [31:0]        s_wdata,
  input  wire logic [3:0]         s_wstrb,
  input  wire logic               s_wvalid,
  output var  logic               s_wready,
  output var  logic [1:0]         s_bresp,
  output var  logic               s_bvalid,
  input  wire logic               s_bready,
  // axi4-lite read
  input  wire logic [3:0]         s_araddr,
  input  wire logic               s_arvalid,
  output var  logic               s_arready,
  output var  logic [31:0]        s_rdata,
  output var  logic [1:0]         s_rresp,
  output var  logic               s_rvalid,
  input  wire logic               s_rready,
  // protocol engine side
  input  wire logic               bit_tick,
  input  wire logic               bus_recessive,
  input  wire logic               device_idle,
  input  wire logic [TX_BUFS-1:0] tx_pending,
  input  wire logic               rx_done,
  // steering outputs
  output var  cmf_pkg::cmf_ctrl_s ctrl,
  output var  logic               capture_evt
);

  logic [15:0] ctrl_q;
  logic [15:0] fen_q;
  logic [15:0] bufpnt_q;
  logic [2:0]  mode_q;
  logic [3:0]  idle_cnt_q;
  logic        bus_idle;
  logic [3:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic        do_write;
  logic        abort_done;
  logic [15:0] wmask;
  logic [31:0] rd_word;
  logic        rd_hit;

  // write channel capture, either order
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end else if (ce) begin
      if (s_awvalid && s_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_wdata;
        w_strb_q <= s_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  assign do_write = aw_have_q && w_have_q && !s_bvalid;
  assign wmask    = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // ready flags and write response
  always_ff @(posedge clk) begin
    if (rst) begin
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= cmf_pkg::RESP_OKAY;
    end else if (ce) begin
      s_awready <= !aw_have_q && !(s_awvalid && s_awready);
      s_wready  <= !w_have_q && !(s_wvalid && s_wready);
      if (do_write) begin
        s_bvalid <= 1'b1;
        s_bresp  <= (aw_addr_q == cmf_pkg::STAT_OFF || aw_addr_q > cmf_pkg::STAT_OFF) ?
                    cmf_pkg::RESP_SLVERR : cmf_pkg::RESP_OKAY;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // bus idle counter over recessive bits
  // eleven recessive bits
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_cnt_q <= 4'h0;
    end else if (ce && bit_tick) begin
      if (!bus_recessive) begin
        idle_cnt_q <= 4'h0;
      end else if (idle_cnt_q < 4'(cmf_pkg::IDLE_BITS)) begin
        idle_cnt_q <= idle_cnt_q + 4'h1;
      end
    end
  end

  assign bus_idle   = (idle_cnt_q == 4'(cmf_pkg::IDLE_BITS));
  assign abort_done = ~|tx_pending;

  // control register: software writes, abort self-clear
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= {2'b00, 1'b0, 1'b0, 1'b0, cmf_pkg::REQ_RST, 8'h00};
    end else if (ce) begin
      if (do_write && aw_addr_q == cmf_pkg::CTRL_OFF) begin
        // writable fields only, status bits kept out
        ctrl_q <= (w_data_q[15:0] & wmask & 16'h3f09) | (ctrl_q & ~(wmask & 16'h3f09));
      end else if (ctrl_q[cmf_pkg::ABORT_BIT] && abort_done) begin
        ctrl_q[cmf_pkg::ABORT_BIT] <= 1'b0;
      end
    end
  end

  // mode status follows request only when bus idle
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= cmf_pkg::STAT_RST;
    end else if (ce) begin
      if (bus_idle && ctrl_q[10:8] != cmf_pkg::MODE_RSV5 &&
          ctrl_q[10:8] != cmf_pkg::MODE_RSV6) begin
        mode_q <= ctrl_q[10:8];
      end
    end
  end

  // filter enable and buffer pointer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      fen_q    <= cmf_pkg::FEN_RST;
      bufpnt_q <= cmf_pkg::BUFPNT_RST;
    end else if (ce && do_write) begin
      if (aw_addr_q == cmf_pkg::FEN_OFF) begin
        fen_q <= (w_data_q[15:0] & wmask) | (fen_q & ~wmask);
      end
      if (aw_addr_q == cmf_pkg::BUFPNT_OFF) begin
        bufpnt_q <= (w_data_q[15:0] & wmask) | (bufpnt_q & ~wmask);
      end
    end
  end

  // read mux, status in bits 7:5
  always_comb begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    unique case (s_araddr)
      cmf_pkg::CTRL_OFF:   rd_word = {16'h0, ctrl_q[15:8], mode_q, ctrl_q[4:0]};
      cmf_pkg::FEN_OFF:    rd_word = {16'h0, fen_q};
      cmf_pkg::BUFPNT_OFF: rd_word = {16'h0, bufpnt_q};
      cmf_pkg::STAT_OFF:   rd_word = {27'h0, bus_idle, idle_cnt_q};
      default:             rd_hit  = 1'b0;
    endcase
  end

  // read channel
  always_ff @(posedge clk) begin
    if (rst) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0;
      s_rresp   <= cmf_pkg::RESP_OKAY;
    end else if (ce) begin
      s_arready <= !s_rvalid && !(s_arvalid && s_arready);
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_word;
        s_rresp  <= rd_hit ? cmf_pkg::RESP_OKAY : cmf_pkg::RESP_SLVERR;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // steering outputs, registered
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl        <= '0;
      capture_evt <= 1'b0;
    end else if (ce) begin
      ctrl.mode           <= mode_q;
      ctrl.abort_req      <= ctrl_q[cmf_pkg::ABORT_BIT];
      ctrl.clk_double     <= ctrl_q[cmf_pkg::CLK_SEL_BIT];
      ctrl.stopped        <= ctrl_q[cmf_pkg::IDLE_STOP_BIT] && device_idle;
      ctrl.capture_en     <= ctrl_q[cmf_pkg::CAP_BIT];
      ctrl.window_filters <= ctrl_q[cmf_pkg::WIN_BIT];
      ctrl.filter_en      <= fen_q;
      ctrl.buf_ptr        <= bufpnt_q;
      capture_evt         <= rx_done && ctrl_q[cmf_pkg::CAP_BIT] &&
                             !(ctrl_q[cmf_pkg::IDLE_STOP_BIT] && device_idle);
    end
  end

  // mode moves only when bus idle
  property p_mode_gated;
    @(posedge clk) disable iff (rst)
      (ce && !bus_idle) |=> $stable(mode_q);
  endproperty
  a_mode_gated: assert property (p_mode_gated) else $error("mode changed while bus busy");

  // abort clears after done
  property p_abort_clear;
    @(posedge clk) disable iff (rst)
      (ce && ctrl_q[12] && abort_done && !do_write) |=> !ctrl_q[12];
  endproperty
  a_abort_clear: assert property (p_abort_clear) else $error("abort not cleared");

  // capture event needs enable
  property p_cap;
    @(posedge clk) disable iff (rst)
      capture_evt |-> $past(ctrl_q[3]) && $past(rx_done);
  endproperty
  a_cap: assert property (p_cap) else $error("capture without enable");

  // status never reserved
  property p_no_rsv;
    @(posedge clk) disable iff (rst)
      mode_q != cmf_pkg::MODE_RSV5 && mode_q != cmf_pkg::MODE_RSV6;
  endproperty
  a_no_rsv: assert property (p_no_rsv) else $error("reserved mode entered");

  // a usable request meets an idle bus; the mode must take it next cycle
  sequence s_switch_ok;
    ce && bus_idle && ctrl_q[10:8] != cmf_pkg::MODE_RSV5 && ctrl_q[10:8] != cmf_pkg::MODE_RSV6;
  endsequence

  // mode takes the request current at the switch point
  property p_mode_follow;
    @(posedge clk) disable iff (rst)
      s_switch_ok |=> mode_q == $past(ctrl_q[10:8]);
  endproperty
  a_mode_follow: assert property (p_mode_follow) else $error("mode did not follow request");

  // a reserved request code is held but never acted on
  sequence s_req_reserved;
    ce && (ctrl_q[10:8] == cmf_pkg::MODE_RSV5 || ctrl_q[10:8] == cmf_pkg::MODE_RSV6);
  endsequence

  // reserved request leaves the mode alone, idle bus or not
  property p_rsv_hold;
    @(posedge clk) disable iff (rst)
      s_req_reserved |=> $stable(mode_q);
  endproperty
  a_rsv_hold: assert property (p_rsv_hold) else $error("reserved request changed mode");

  // stop output follows idle-stop and device idle one cycle later
  property p_stop;
    @(posedge clk) disable iff (rst)
      ce |=> ctrl.stopped == $past(ctrl_q[cmf_pkg::IDLE_STOP_BIT] && device_idle);
  endproperty
  a_stop: assert property (p_stop) else $error("stop output wrong");

  // pointer register moves only on a write aimed at it
  property p_ptr_hold;
    @(posedge clk) disable iff (rst)
      (ce && !(do_write && aw_addr_q == cmf_pkg::BUFPNT_OFF)) |=> $stable(bufpnt_q);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed without write");

endmodule

`default_nettype wire

// >>> tb/cmf_bus_model.sv
/*
 * far side of the block: other nodes on the can bus, seen as a bit
 * strobe, the sampled bus level and a receive strobe.
 * assumes one clock shared with the block under test.
 */
`timescale 1ns/100ps
`default_nettype none
module cmf_bus_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // bench control
  input  wire logic busy,
  input  wire logic rx_send,
  // toward the block
  output var  logic bit_tick,
  output var  logic bus_recessive,
  output var  logic rx_done
);
  logic [1:0] div_q;
  // one can bit every four clocks
  always_ff @(posedge clk) begin
    div_q    <= rst ? 2'h0 : div_q + 2'h1;
    bit_tick <= !rst && div_q == 2'h3;
  end
  // dominant traffic while busy, recessive pull otherwise
  always_ff @(posedge clk) begin
    bus_recessive <= !busy;
    rx_done       <= rx_send;
  end
endmodule
`default_nettype wire

// >>> tb/test_can_mode_and_filter_control.sv
/*
 * self-checking bench for the can mode and filter control block.
 * assumes the cmf package, the block and the bus model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module test_can_mode_and_filter_control;
  logic               clk = 1'b0, rst = 1'b1, ce = 1'b1, busy = 1'b1, rx_send = 1'b0, device_idle = 1'b0;
  logic               s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [3:0]         s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'h3;
  logic [31:0]        s_wdata = 32'h0, s_rdata, rd_v;
  logic [7:0]         tx_pending = 8'h0;
  logic               s_awready, s_wready, s_bvalid, s_arready, s_rvalid, bit_tick, bus_recessive, rx_done;
  logic               capture_evt;
  logic [1:0]         s_bresp, s_rresp;
  logic [15:0]        sh, v;
  logic [2:0]         st;
  logic [2:0]         modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5};
  logic [33:0]        exp_q [$];
  cmf_pkg::cmf_ctrl_s ctrl;
  int                 n_errors = 0, n_compared = 0, cyc = 0, n_cap = 0, c0, seed = 19;

  // 20 mhz clock
  always #25 clk = ~clk;

  cmf_top #(.TX_BUFS(8)) uut (.clk, .rst, .ce, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .bit_tick, .bus_recessive, .device_idle, .tx_pending, .rx_done,
    .ctrl, .capture_evt);

  cmf_bus_model bus (.clk, .rst, .busy, .rx_send, .bit_tick, .bus_recessive, .rx_done);

  task automatic final_report();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // watcher: timeout, capture pulses, response compares
  always @(posedge clk) begin
    cyc++;
    if (capture_evt)
      n_cap++;
    if (s_bvalid && s_bready && exp_q.size() > 0)
      check({s_bresp, 32'h0}, exp_q.pop_front());
    if (s_rvalid && s_rready && exp_q.size() > 0)
      check({s_rresp, s_rdata}, exp_q.pop_front());
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    exp_q.push_back({r, 32'h0});
    s_awaddr <= a;
    s_wdata <= {16'h0, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      ad = ad || s_awready;
      wd = wd || s_wready;
      s_awvalid <= !ad;
      s_wvalid <= !wd;
    end
    while (!s_bvalid)
      @(posedge clk);
    s_bready <= 1'b0;
    @(posedge clk);
  endtask

  // read, optionally noting the expected response
  task automatic rd(input logic [3:0] a, input logic push, input logic [33:0] e);
    if (push)
      exp_q.push_back(e);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge clk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge clk); while (!s_rvalid);
    rd_v = s_rdata;
    s_rready <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [33:0] ec();
    return {18'h0, sh | {8'h0, st, 5'h0}};
  endfunction

  task automatic wc(input logic [15:0] d);
    sh = d & 16'h3f09;
    wr(4'h0, d, 2'h0);
  endtask

  task automatic rx();
    rx_send <= 1'b1;
    @(posedge clk);
    rx_send <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    sh = 16'h0400;
    st = 3'h4;
    rd(4'h0, 1'b1, ec());
    rd(4'h4, 1'b1, 34'hffff);
    rd(4'h8, 1'b1, 34'h0);
    for (int i = 0; i < 2; i++) begin
      v = 16'($random(seed));
      wr(4'h4 + 4'(4 * i), v, 2'h0);
      rd(4'h4 + 4'(4 * i), 1'b1, {18'h0, v});
      check(i == 0 ? ctrl.filter_en : ctrl.buf_ptr, v);
    end
    wr(4'hc, 16'h1234, 2'h2);
    tx_pending <= 8'h81;
    wc(16'h1400);
    rd(4'h0, 1'b1, ec());
    check(ctrl.abort_req, 1'b1);
    tx_pending <= 8'h00;
    repeat (3) @(posedge clk);
    sh[12] = 1'b0;
    rd(4'h0, 1'b1, ec());
    wc(16'h2c09);
    check({ctrl.clk_double, ctrl.window_filters, ctrl.capture_en}, 3'h7);
    c0 = n_cap;
    rx();
    check(n_cap, c0 + 1);
    device_idle <= 1'b1;
    repeat (2) @(posedge clk);
    check(ctrl.stopped, 1'b1);
    rx();
    check(n_cap, c0 + 1);
    device_idle <= 1'b0;
    wc(16'h0400);
    for (int i = 0; i < 6; i++) begin
      busy <= 1'b1;
      repeat (3) @(posedge clk);
      wc({5'h0, 3'($random(seed)) & 3'h3, 8'h0});
      wc({5'h0, modes[i], 8'h0});
      repeat (60) @(posedge clk);
      rd(4'h0, 1'b1, ec());
      busy <= 1'b0;
      if (modes[i] != 3'h5)
        st = modes[i];
      for (int k = 0; k < 40 && rd_v[7:5] !== st; k++)
        rd(4'h0, 1'b0, 34'h0);
      repeat (60) @(posedge clk);
      rd(4'h0, 1'b1, ec());
      check(ctrl.mode, st);
    end
    // a low clock enable freezes the idle count and the mode
    busy <= 1'b1;
    repeat (3) @(posedge clk);
    wc(16'h0000);
    ce <= 1'b0;
    busy <= 1'b0;
    repeat (80) @(posedge clk);
    check(ctrl.mode, st);
    ce <= 1'b1;
    st = 3'h0;
    repeat (80) @(posedge clk);
    check(ctrl.mode, st);
    rd(4'hc, 1'b1, 34'h1b);
    check(exp_q.size(), 0);
    final_report();
  end
endmodule
`default_nettype wire
